// [inc/dao_pkg.sv]
// Shared constants and types of the dual converter output control block.
package dao_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int CHANS = 2;
  localparam int DW = 14;
  localparam int AW = 8;

  // ----------------------------------------------------------------------
  // Register offsets, fields and reset values
  // ----------------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [AW-1:0] OFS_SNAP_A = 8'h10;
  localparam logic [AW-1:0] OFS_SNAP_B = 8'h14;
  localparam int CTRL_FREEZE_BIT = 0;
  localparam int ST_STATE_B_LSB = 4;
  localparam int ST_TWOS_BIT = 8;
  localparam int ST_DCS_BIT = 9;
  localparam int ST_VALID_LSB = 10;
  localparam int ST_SWAP_BIT = 12;
  localparam int IRQ_OVF_LSB = 0;
  localparam int IRQ_RDY_LSB = 2;
  localparam int IRQ_W = 4;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------------
  // Strap levels and code end points
  // ----------------------------------------------------------------------
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_THIRD = 2'h1;
  localparam logic [1:0] STRAP_TWO_THIRD = 2'h2;
  localparam logic [1:0] STRAP_VDD = 2'h3;
  localparam logic [DW-1:0] CODE_MAX = 14'h3fff;
  localparam logic [DW-1:0] CODE_MIN = 14'h0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int NAP_WAKE_EDGES = 100;
  localparam int RELOCK_EDGES = 100;
  localparam int SLEEP_WAKE_MS = 2;
  localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_MS * CLK_KHZ;
  localparam int STOP_US = 10;
  localparam int STOP_CYC = (STOP_US * CLK_KHZ + 999) / 1000;
  localparam int CNT_W = 20;

  // ----------------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_RUN,
    PWR_NAP,
    PWR_SLEEP,
    PWR_WAKE_NAP,
    PWR_WAKE_SLEEP
  } dao_pwr_t;

endpackage : dao_pkg

// [rtl/dao_sync.sv]
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ns
module dao_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : dao_sync

// [rtl/dao_code_fmt.sv]
// Output code register with clamping and format selection.
`timescale 1ns/1ns
module dao_code_fmt (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sample in
  input wire logic load,
  input wire logic [dao_pkg::DW-1:0] raw_code,
  input wire logic over,
  input wire logic under,
  input wire logic twos,
  // Sample out
  output logic [dao_pkg::DW-1:0] code_reg,
  output logic ovf_reg
);

  logic [dao_pkg::DW-1:0] clamp;

  // Raw code is offset binary; mid-scale is the top bit alone.
  always_comb
  begin
    if (over)
      clamp = dao_pkg::CODE_MAX;
    else if (under)
      clamp = dao_pkg::CODE_MIN;
    else
      clamp = raw_code;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_reg <= dao_pkg::CODE_MIN;
      ovf_reg <= 1'b0;
    end
    else if (load)
    begin
      // Two's complement is offset binary with the top bit inverted.
      code_reg <= {clamp[dao_pkg::DW-1] ^ twos, clamp[dao_pkg::DW-2:0]};
      ovf_reg <= over | under;
    end
  end

endmodule : dao_code_fmt

// [rtl/dao_top.sv]
// Dual converter output, power state and register control.
`timescale 1ns/1ns
module dao_top #(
  parameter int SLEEP_WAKE_CYC = dao_pkg::SLEEP_WAKE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dao_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Control pins
  input wire logic [1:0] strap_level,
  input wire logic bus_swap_select,
  input wire logic sample_clock_chan_a,
  input wire logic sample_clock_chan_b,
  input wire logic power_down_request_a,
  input wire logic power_down_request_b,
  input wire logic outputs_off_n_chan_a,
  input wire logic outputs_off_n_chan_b,
  // Converter core results
  input wire logic [dao_pkg::DW-1:0] core_code_a,
  input wire logic core_over_a,
  input wire logic core_under_a,
  input wire logic [dao_pkg::DW-1:0] core_code_b,
  input wire logic core_over_b,
  input wire logic core_under_b,
  // Bus A pins
  output logic [dao_pkg::DW-1:0] bus_a_sample,
  output logic range_exceeded_bus_a,
  output logic bus_a_oe_n,
  // Bus B pins
  output logic [dao_pkg::DW-1:0] bus_b_sample,
  output logic range_exceeded_bus_b,
  output logic bus_b_oe_n,
  // Channel state
  output logic chan_a_data_valid,
  output logic chan_b_data_valid,
  output logic duty_stabilizer_on,
  output logic twos_complement_on
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic [8:0] pins_raw;
  logic [8:0] pins_s;
  logic [1:0] strap_s;
  logic swap_s;
  logic [1:0] clk_s;
  logic [1:0] power_down_request_s;
  logic [1:0] oen_s;

  assign pins_raw = {strap_level, bus_swap_select,
                     sample_clock_chan_b, sample_clock_chan_a,
                     power_down_request_b, power_down_request_a,
                     outputs_off_n_chan_b, outputs_off_n_chan_a};

  dao_sync #(
    .W(9)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign strap_s = pins_s[8:7];
  assign swap_s = pins_s[6];
  assign clk_s = pins_s[5:4];
  assign power_down_request_s = pins_s[3:2];
  assign oen_s = pins_s[1:0];

  // ----------------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------------
  logic twos;
  logic dcs;

  assign twos = (strap_s == dao_pkg::STRAP_TWO_THIRD) |
                (strap_s == dao_pkg::STRAP_VDD);
  assign dcs = (strap_s == dao_pkg::STRAP_THIRD) |
               (strap_s == dao_pkg::STRAP_TWO_THIRD);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duty_stabilizer_on <= 1'b0;
      twos_complement_on <= 1'b0;
    end
    else
    begin
      duty_stabilizer_on <= dcs;
      twos_complement_on <= twos;
    end
  end

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  logic [dao_pkg::DW-1:0] core_code [dao_pkg::CHANS];
  logic [1:0] core_over;
  logic [1:0] core_under;
  logic [dao_pkg::DW-1:0] code [dao_pkg::CHANS];
  logic [1:0] ovf;
  logic [1:0] on;
  logic [1:0] valid;
  logic [1:0] ovf_evt;
  logic [1:0] rdy_evt;
  dao_pkg::dao_pwr_t state [dao_pkg::CHANS];

  assign core_code[0] = core_code_a;
  assign core_code[1] = core_code_b;
  assign core_over = {core_over_b, core_over_a};
  assign core_under = {core_under_b, core_under_a};

  genvar c;
  generate
    for (c = 0; c < dao_pkg::CHANS; c++)
    begin : g_chan
      logic clk_d_reg;
      logic edge_s;
      logic [8:0] idle_cnt_reg;
      logic stopped;
      logic [6:0] relock_reg;
      logic relocked;
      logic [dao_pkg::CNT_W-1:0] wake_reg;
      logic wake_tick;
      logic wake_done;
      logic load;
      logic valid_d_reg;
      dao_pkg::dao_pwr_t state_reg;
      dao_pkg::dao_pwr_t state_next;

      // Rising sample clock edges only; the falling edge plays no part.
      assign edge_s = clk_s[c] & ~clk_d_reg;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          clk_d_reg <= 1'b0;
        else
          clk_d_reg <= clk_s[c];
      end

      // Clock stop watchdog.
      assign stopped = idle_cnt_reg == 9'(dao_pkg::STOP_CYC);

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          idle_cnt_reg <= '0;
        else if (edge_s)
          idle_cnt_reg <= '0;
        else if (!stopped)
          idle_cnt_reg <= idle_cnt_reg + 9'h001;
      end

      // Stabilizer relock count after a stopped clock.
      assign relocked = relock_reg == 7'(dao_pkg::RELOCK_EDGES);

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          relock_reg <= '0;
        else if (stopped || !dcs)
          relock_reg <= '0;
        else if (edge_s && !relocked)
          relock_reg <= relock_reg + 7'h01;
      end

      // Recovery count after nap or sleep exit.
      assign wake_tick = (state_reg == dao_pkg::PWR_WAKE_SLEEP) ||
                         ((state_reg == dao_pkg::PWR_WAKE_NAP) &&
                          edge_s);
      assign wake_done = wake_tick &&
        (((state_reg == dao_pkg::PWR_WAKE_NAP) &&
          (wake_reg == dao_pkg::CNT_W'(dao_pkg::NAP_WAKE_EDGES - 1))) ||
         ((state_reg == dao_pkg::PWR_WAKE_SLEEP) &&
          (wake_reg == dao_pkg::CNT_W'(SLEEP_WAKE_CYC - 1))));

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          wake_reg <= '0;
        else if (state_next != state_reg)
          wake_reg <= '0;
        else if (wake_tick)
          wake_reg <= wake_reg + dao_pkg::CNT_W'(1);
      end

      // Power state from this channel's own shutdown and enable only.
      always_comb
      begin
        state_next = state_reg;
        case (state_reg)
          dao_pkg::PWR_RUN:
          begin
            if (power_down_request_s[c] && oen_s[c])
              state_next = dao_pkg::PWR_SLEEP;
            else if (power_down_request_s[c])
              state_next = dao_pkg::PWR_NAP;
          end
          dao_pkg::PWR_NAP:
          begin
            if (!power_down_request_s[c])
              state_next = dao_pkg::PWR_WAKE_NAP;
            else if (oen_s[c])
              state_next = dao_pkg::PWR_SLEEP;
          end
          dao_pkg::PWR_SLEEP:
          begin
            if (!power_down_request_s[c])
              state_next = dao_pkg::PWR_WAKE_SLEEP;
            else if (!oen_s[c])
              state_next = dao_pkg::PWR_NAP;
          end
          dao_pkg::PWR_WAKE_NAP, dao_pkg::PWR_WAKE_SLEEP:
          begin
            if (power_down_request_s[c] && oen_s[c])
              state_next = dao_pkg::PWR_SLEEP;
            else if (power_down_request_s[c])
              state_next = dao_pkg::PWR_NAP;
            else if (wake_done)
              state_next = dao_pkg::PWR_RUN;
          end
          default:
            state_next = dao_pkg::PWR_RUN;
        endcase
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          state_reg <= dao_pkg::PWR_RUN;
        else
          state_reg <= state_next;
      end

      // Converter runs in every state except nap and sleep.
      assign on[c] = (state_reg != dao_pkg::PWR_NAP) &&
                     (state_reg != dao_pkg::PWR_SLEEP);
      assign load = edge_s && on[c];
      assign valid[c] = (state_reg == dao_pkg::PWR_RUN) &&
                        (relocked || !dcs);
      assign ovf_evt[c] = load && (core_over[c] || core_under[c]);
      assign rdy_evt[c] = valid[c] && !valid_d_reg;
      assign state[c] = state_reg;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          valid_d_reg <= 1'b0;
        else
          valid_d_reg <= valid[c];
      end

      dao_code_fmt u_fmt (
        .pclk(pclk),
        .presetn(presetn),
        .load(load),
        .raw_code(core_code[c]),
        .over(core_over[c]),
        .under(core_under[c]),
        .twos(twos),
        .code_reg(code[c]),
        .ovf_reg(ovf[c])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_a_data_valid <= 1'b0;
      chan_b_data_valid <= 1'b0;
    end
    else
    begin
      chan_a_data_valid <= valid[0];
      chan_b_data_valid <= valid[1];
    end
  end

  // ----------------------------------------------------------------------
  // Output bus routing and enables
  // ----------------------------------------------------------------------
  logic src_a;
  logic src_b;

  assign src_a = swap_s ? 1'b0 : 1'b1;
  assign src_b = swap_s ? 1'b1 : 1'b0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_a_sample <= dao_pkg::CODE_MIN;
      bus_b_sample <= dao_pkg::CODE_MIN;
      range_exceeded_bus_a <= 1'b0;
      range_exceeded_bus_b <= 1'b0;
    end
    else
    begin
      bus_a_sample <= code[src_a];
      bus_b_sample <= code[src_b];
      range_exceeded_bus_a <= ovf[src_a];
      range_exceeded_bus_b <= ovf[src_b];
    end
  end

  // Each bus enable follows its own pin and the routed channel's power.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_a_oe_n <= 1'b1;
      bus_b_oe_n <= 1'b1;
    end
    else
    begin
      bus_a_oe_n <= oen_s[0] | ~on[src_a];
      bus_b_oe_n <= oen_s[1] | ~on[src_b];
    end
  end

  // ----------------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------------
  logic freeze_reg;
  logic [dao_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [dao_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [dao_pkg::IRQ_W-1:0] irq_set;
  logic [dao_pkg::IRQ_W-1:0] irq_clr;
  logic [dao_pkg::DW:0] snap_a_reg;
  logic [dao_pkg::DW:0] snap_b_reg;
  logic [31:0] status;
  logic [31:0] rd_next;
  logic hit;
  logic setup;
  logic access;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  always_comb
  begin
    status = 32'h0000_0000;
    status[2:0] = state[0];
    status[dao_pkg::ST_STATE_B_LSB +: 3] = state[1];
    status[dao_pkg::ST_TWOS_BIT] = twos;
    status[dao_pkg::ST_DCS_BIT] = dcs;
    status[dao_pkg::ST_VALID_LSB +: 2] = valid;
    status[dao_pkg::ST_SWAP_BIT] = swap_s;
  end

  always_comb
  begin
    rd_next = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == dao_pkg::OFS_CTRL)
      rd_next[dao_pkg::CTRL_FREEZE_BIT] = freeze_reg;
    else if (paddr == dao_pkg::OFS_STATUS)
      rd_next = status;
    else if (paddr == dao_pkg::OFS_IRQ_STAT)
      rd_next[dao_pkg::IRQ_W-1:0] = irq_stat_reg;
    else if (paddr == dao_pkg::OFS_IRQ_MASK)
      rd_next[dao_pkg::IRQ_W-1:0] = irq_mask_reg;
    else if (paddr == dao_pkg::OFS_SNAP_A)
      rd_next[dao_pkg::DW:0] = snap_a_reg;
    else if (paddr == dao_pkg::OFS_SNAP_B)
      rd_next[dao_pkg::DW:0] = snap_b_reg;
    else
      hit = 1'b0;
  end

  // Read data is captured in the setup cycle and held for the access.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freeze_reg <= dao_pkg::CTRL_RST;
      irq_mask_reg <= dao_pkg::IRQ_MASK_RST;
    end
    else if (access && pwrite)
    begin
      if (paddr == dao_pkg::OFS_CTRL)
        freeze_reg <= pwdata[dao_pkg::CTRL_FREEZE_BIT];
      else if (paddr == dao_pkg::OFS_IRQ_MASK)
        irq_mask_reg <= pwdata[dao_pkg::IRQ_W-1:0];
    end
  end

  // Snapshots of the latest code per channel, held while frozen.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snap_a_reg <= '0;
      snap_b_reg <= '0;
    end
    else if (!freeze_reg)
    begin
      snap_a_reg <= {ovf[0], code[0]};
      snap_b_reg <= {ovf[1], code[1]};
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  assign irq_set = {rdy_evt, ovf_evt};
  // Only the bits that the read returned are cleared; new events win.
  assign irq_clr = (access && !pwrite && paddr == dao_pkg::OFS_IRQ_STAT) ?
                   prdata[dao_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule : dao_top

// [testbench/dao_checker_properties.sv]
// Concurrent checks on the pins of the output control block.
`timescale 1ns/1ns
module dao_checker #(
  parameter int SLEEP_WAKE_CYC = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control pins
  input wire logic [1:0] strap_level,
  input wire logic power_down_request_a,
  input wire logic power_down_request_b,
  input wire logic outputs_off_n_chan_a,
  input wire logic outputs_off_n_chan_b,
  // Buses and state
  input wire logic [dao_pkg::DW-1:0] bus_a_sample,
  input wire logic [dao_pkg::DW-1:0] bus_b_sample,
  input wire logic range_exceeded_bus_a,
  input wire logic range_exceeded_bus_b,
  input wire logic bus_a_oe_n,
  input wire logic bus_b_oe_n,
  input wire logic chan_a_data_valid,
  input wire logic chan_b_data_valid,
  input wire logic duty_stabilizer_on,
  input wire logic twos_complement_on
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_FORMAT: assert property (
    $stable(strap_level)[*5] |-> twos_complement_on == strap_level[1])
    else $error("format flag does not follow strap");
  AST_STABILIZER: assert property (
    $stable(strap_level)[*5] |->
    duty_stabilizer_on == (strap_level[1] ^ strap_level[0]))
    else $error("stabilizer flag does not follow strap");
  AST_OE_A: assert property (
    outputs_off_n_chan_a[*5] |-> bus_a_oe_n)
    else $error("bus A driven while disabled");
  AST_OE_B: assert property (
    outputs_off_n_chan_b[*5] |-> bus_b_oe_n)
    else $error("bus B driven while disabled");
  AST_DOWN_A: assert property (
    power_down_request_a[*6] |-> !chan_a_data_valid)
    else $error("channel A valid while powered down");
  AST_DOWN_B: assert property (
    power_down_request_b[*6] |-> !chan_b_data_valid)
    else $error("channel B valid while powered down");
  AST_CLAMP_A: assert property (
    range_exceeded_bus_a && !bus_a_oe_n |->
    bus_a_sample inside {14'h3fff, 14'h0000, 14'h1fff, 14'h2000})
    else $error("bus A overflow without end code");
  AST_CLAMP_B: assert property (
    range_exceeded_bus_b && !bus_b_oe_n |->
    bus_b_sample inside {14'h3fff, 14'h0000, 14'h1fff, 14'h2000})
    else $error("bus B overflow without end code");
endmodule : dao_checker

// [testbench/dao_capture.sv]
// Capture-side model that resolves the two output buses.
`timescale 1ns/1ns
module dao_capture (
  // Clock
  input wire logic pclk,
  // Bus A
  input wire logic [dao_pkg::DW-1:0] bus_a_sample,
  input wire logic range_exceeded_bus_a,
  input wire logic bus_a_oe_n,
  // Bus B
  input wire logic [dao_pkg::DW-1:0] bus_b_sample,
  input wire logic range_exceeded_bus_b,
  input wire logic bus_b_oe_n,
  // Resolved lines
  output logic [dao_pkg::DW:0] line_a,
  output logic [dao_pkg::DW:0] line_b
);
  logic [dao_pkg::DW:0] last_a_reg;
  logic [dao_pkg::DW:0] last_b_reg;

  // Released lines show a changing pattern, never the last value.
  always_comb line_a = bus_a_oe_n ? ~last_a_reg :
    {range_exceeded_bus_a, bus_a_sample};
  always_comb line_b = bus_b_oe_n ? ~last_b_reg :
    {range_exceeded_bus_b, bus_b_sample};
  always_ff @(posedge pclk)
  begin
    last_a_reg <= line_a;
    last_b_reg <= line_b;
  end
endmodule : dao_capture

// [testbench/tb_top.sv]
// Self-checking bench of the dual converter output control block.
`timescale 1ns/1ns
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] strap_level;
  logic bus_swap_select, sample_clock_chan_a, sample_clock_chan_b;
  logic power_down_request_a, power_down_request_b;
  logic outputs_off_n_chan_a, outputs_off_n_chan_b;
  logic [13:0] core_code_a, core_code_b, bus_a_sample, bus_b_sample;
  logic core_over_a, core_under_a, core_over_b, core_under_b;
  logic range_exceeded_bus_a, range_exceeded_bus_b, bus_a_oe_n, bus_b_oe_n;
  logic chan_a_data_valid, chan_b_data_valid;
  logic duty_stabilizer_on, twos_complement_on, run_a, er, tie_swap;
  logic swap_pin;
  logic [14:0] line_a, line_b;
  logic [2:0] cdiv = 3'h0;
  logic [13:0] e;
  int err_total, compares, n;

  dao_top #(.SLEEP_WAKE_CYC(20)) dao_top_i (.*);
  dao_capture dao_capture_i (.*);
  assign bus_swap_select = tie_swap ? sample_clock_chan_b : swap_pin;

  // ----------------------------------------
  // Clocks
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cdiv <= cdiv + 3'd1;
    sample_clock_chan_a <= run_a & cdiv[2];
    sample_clock_chan_b <= cdiv[2];
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'h0000_0001;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 50)
    begin
      err_total++;
      report_and_stop();
    end
  endtask : apb
  task automatic wait_valid(input logic b);
    n = 0;
    while ((b ? chan_b_data_valid : chan_a_data_valid) !== 1'b1)
    begin
      @(posedge pclk);
      n++;
      if (n > 3000)
      begin
        err_total++;
        report_and_stop();
      end
    end
  endtask : wait_valid

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_format;
    for (int s = 0; s < 4; s++)
    begin
      strap_level <= s[1:0];
      core_code_a <= 14'h2000 + 14'(s);
      cyc(16);
      e = (14'h2000 + 14'(s)) ^ (s[1] ? 14'h2000 : 14'h0000);
      chk("fmt_a", {1'b0, e}, line_a);
      chk("twos", s[1], twos_complement_on);
      chk("dcs", s[1] ^ s[0], duty_stabilizer_on);
    end
    for (int k = 0; k < 4; k++)
    begin
      strap_level <= k[1] ? 2'h3 : 2'h0;
      core_over_a <= ~k[0];
      core_under_a <= k[0];
      core_over_b <= ~k[0];
      core_under_b <= k[0];
      cyc(16);
      e = (k[0] ? 14'h0000 : 14'h3fff) ^ (k[1] ? 14'h2000 : 14'h0000);
      chk("clamp_a", {1'b1, e}, line_a);
      chk("clamp_b", {1'b1, e}, line_b);
    end
    core_under_a <= 1'b0;
    core_under_b <= 1'b0;
    cyc(16);
    chk("no_ovf", 1'b0, line_a[14]);
    $display("test format done");
  endtask : t_format
  task automatic t_swap_oe;
    strap_level <= 2'h0;
    core_code_a <= 14'h1234;
    core_code_b <= 14'h0abc;
    for (int w = 0; w < 2; w++)
    begin
      swap_pin <= w[0];
      cyc(16);
      chk("swap_a", w ? 15'h1234 : 15'h0abc, line_a);
      chk("swap_b", w ? 15'h0abc : 15'h1234, line_b);
    end
    outputs_off_n_chan_a <= 1'b1;
    cyc(8);
    chk("oe_a", 1'b1, bus_a_oe_n);
    chk("oe_b", 15'h0abc, line_b);
    chk("run_a", 1'b1, chan_a_data_valid);
    outputs_off_n_chan_a <= 1'b0;
    outputs_off_n_chan_b <= 1'b1;
    cyc(8);
    chk("oe_b_off", 1'b1, bus_b_oe_n);
    chk("oe_a_on", 15'h1234, line_a);
    tie_swap <= 1'b1;
    cyc(16);
    repeat (8)
      if (cdiv != 3'h4)
        cyc(1);
    cyc(5);
    chk("mux_hi", 15'h1234, line_a);
    cyc(4);
    chk("mux_lo", 15'h0abc, line_a);
    tie_swap <= 1'b0;
    outputs_off_n_chan_b <= 1'b0;
    $display("test swap done");
  endtask : t_swap_oe
  task automatic t_power;
    power_down_request_b <= 1'b1;
    cyc(12);
    chk("nap_b", 1'b0, chan_b_data_valid);
    chk("nap_oe", 1'b1, bus_b_oe_n);
    chk("other_a", 1'b1, chan_a_data_valid);
    power_down_request_b <= 1'b0;
    wait_valid(1'b1);
    chk("nap_wake", 1'b1, n >= 780);
    power_down_request_a <= 1'b1;
    outputs_off_n_chan_a <= 1'b1;
    cyc(12);
    chk("sleep_a", 1'b0, chan_a_data_valid);
    chk("sleep_oe", 1'b1, bus_a_oe_n);
    power_down_request_a <= 1'b0;
    wait_valid(1'b0);
    chk("sleep_wake", 1'b1, n >= 20 && n < 200);
    outputs_off_n_chan_a <= 1'b0;
    strap_level <= 2'h1;
    run_a <= 1'b0;
    cyc(320);
    chk("stop_a", 1'b0, chan_a_data_valid);
    run_a <= 1'b1;
    wait_valid(1'b0);
    chk("relock", 1'b1, n >= 780);
    $display("test power done");
  endtask : t_power
  task automatic t_irq;
    core_over_a <= 1'b1;
    cyc(16);
    chk("irq_masked", 1'b0, irq);
    apb(1'b1, 8'h0c);
    cyc(2);
    chk("irq_on", 1'b1, irq);
    core_over_a <= 1'b0;
    cyc(16);
    apb(1'b0, 8'h08);
    chk("stat_set", 1'b1, rd[0]);
    apb(1'b0, 8'h08);
    chk("stat_clr", 1'b0, rd[0]);
    cyc(2);
    chk("irq_off", 1'b0, irq);
    apb(1'b0, 8'h04);
    chk("st_twos", 1'b0, rd[8]);
    apb(1'b0, 8'h40);
    chk("unmapped", 1'b1, er);
    chk("pready", 1'b1, pready);
    apb(1'b1, 8'h00);
    core_code_a <= 14'h0777;
    cyc(16);
    chk("live_a", 15'h0777, line_a);
    apb(1'b0, 8'h10);
    chk("snap_hold", 32'h0000_1234, rd);
    apb(1'b0, 8'h00);
    chk("freeze", 1'b1, rd[0]);
    $display("test irq done");
  endtask : t_irq

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {strap_level, power_down_request_a, power_down_request_b} = '0;
    {outputs_off_n_chan_a, outputs_off_n_chan_b} = '0;
    {core_code_a, core_code_b, core_over_a, core_under_a} = '0;
    {core_over_b, core_under_b} = '0;
    swap_pin = 1'b1;
    tie_swap = 1'b0;
    run_a = 1'b1;
    err_total = 0;
    compares = 0;
    cyc(12);
    presetn <= 1'b1;
    cyc(4);
    t_format();
    t_swap_oe();
    t_power();
    t_irq();
    report_and_stop();
  end
endmodule : tb_top

bind dao_top dao_checker #(.SLEEP_WAKE_CYC(SLEEP_WAKE_CYC)) dao_checker_i (
  .pclk, .presetn, .strap_level, .power_down_request_a,
  .power_down_request_b, .outputs_off_n_chan_a, .outputs_off_n_chan_b,
  .bus_a_sample, .bus_b_sample, .range_exceeded_bus_a,
  .range_exceeded_bus_b, .bus_a_oe_n, .bus_b_oe_n, .chan_a_data_valid,
  .chan_b_data_valid, .duty_stabilizer_on, .twos_complement_on);
